// [supply_command_fault_handler.sv]
// supply command interpreter: delay, errors, fault register, foldback
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/100ps
// ======================================================================
module supply_command_fault_handler #(
    parameter int          TICK_CYCLES = supply_cmd_pkg::TICK_CYCLES,
    parameter logic [15:0] MODEL_NAME  = 16'h0a5a, // arbitrary value
    parameter logic [15:0] FW_VERSION  = 16'h0101, // arbitrary value
    parameter logic [15:0] CAL_LO_VAL  = 16'h0040,
    parameter logic [15:0] CAL_HI_VAL  = 16'hf000
) (
    input  wire logic        MCLK_I,
    input  wire logic        RSTN_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        CV_STATE_I,
    input  wire logic        CC_STATE_I,
    output logic             FAULT_LINE_O,
    output logic             ERR_LED_O,
    output logic             OUTPUT_EN_O
);
    // ==================================================================
    // pin synchronisers: three stages, change accepted when 2 and 3 agree
    logic [2:0] cv_sync_reg;
    logic [2:0] cc_sync_reg;
    logic       cv_reg;
    logic       cc_reg;

    always_ff @(posedge MCLK_I)
    begin
        if (!RSTN_I)
        begin
            cv_sync_reg <= 3'h0;
            cc_sync_reg <= 3'h0;
            cv_reg      <= 1'b0;
            cc_reg      <= 1'b0;
        end
        else
        begin
            cv_sync_reg <= {cv_sync_reg[1:0], CV_STATE_I};
            cc_sync_reg <= {cc_sync_reg[1:0], CC_STATE_I};
            if (cv_sync_reg[1] == cv_sync_reg[2])
                cv_reg <= cv_sync_reg[2];
            if (cc_sync_reg[1] == cc_sync_reg[2])
                cc_reg <= cc_sync_reg[2];
        end
    end

    // ==================================================================
    // apb decode: zero wait states, unmapped address errors
    logic        wr_en;
    logic        rd_en;
    logic        mapped;
    logic        cmd_go;
    logic [7:0]  op;
    logic [15:0] arg;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a[1:0] == 2'h0) && (a <= supply_cmd_pkg::CALOUT_OFF);
    endfunction

    assign mapped    = is_mapped(PADDR_I);
    assign wr_en     = PSEL_I && PENABLE_I && PWRITE_I && mapped;
    assign rd_en     = PSEL_I && PENABLE_I && !PWRITE_I && mapped;
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
    assign cmd_go    = wr_en && (PADDR_I == supply_cmd_pkg::CMD_OFF);
    assign op        = PWDATA_I[31:24];
    assign arg       = PWDATA_I[15:0];

    // ==================================================================
    // state registers
    logic [15:0] delay_set_reg;
    logic [15:0] delay_cnt_reg;
    logic [31:0] tick_cnt_reg;
    logic [7:0]  err_code_reg;
    logic [3:0]  fault_reg;
    logic [3:0]  accum_reg;
    logic [3:0]  mask_reg;     // 1 = condition allowed to report
    logic [1:0]  fold_reg;
    logic        hold_reg;
    logic        cal_reg;
    logic        out_reg;
    logic        tripped_reg;
    logic        discard_reg;
    logic        led_reg;
    logic [15:0] current_setpoint_cmd_reg;
    logic [15:0] voltage_setpoint_cmd_reg;
    logic [15:0] current_setpoint_cmd_pend_reg;
    logic [15:0] voltage_setpoint_cmd_pend_reg;
    logic [15:0] ceil_reg;
    logic [15:0] slope_reg;
    logic [15:0] offset_reg;
    logic [15:0] calout_reg;
    logic [31:0] reply_reg;

    // decoded command events
    logic cmd_ok;
    logic bad_op;
    logic range_err;
    logic ceil_err;
    logic cal_err;
    logic prog_err;
    logic delay_start;
    logic suppress;
    logic cond_cv;
    logic cond_cc;
    logic cond_fold;
    logic [3:0] fault_set;
    logic fault_q;
    logic accum_q;
    logic err_q;
    logic [15:0] eff_current_setpoint_cmd;

    // skipped commands while the rest of a bad line is discarded
    assign cmd_ok = cmd_go && !discard_reg && (op != supply_cmd_pkg::OP_LINE_END);
    assign bad_op = cmd_ok && (op == 8'h00 || op > supply_cmd_pkg::OP_ACCUM_Q);
    assign range_err = cmd_ok && (
        (op == supply_cmd_pkg::OP_DELAY_SET
            && arg > supply_cmd_pkg::DELAY_MAX_TICKS) ||
        (op == supply_cmd_pkg::OP_FOLD_SET && arg > 16'h0002));
    // ceiling compares against the pending value when hold is active
    assign eff_current_setpoint_cmd = hold_reg ? current_setpoint_cmd_pend_reg : current_setpoint_cmd_reg;
    assign ceil_err = cmd_ok && (
        (op == supply_cmd_pkg::OP_CURRENT_SETPOINT_CMD && arg > ceil_reg) ||
        (op == supply_cmd_pkg::OP_CEIL_SET && arg < eff_current_setpoint_cmd));
    assign cal_err = cmd_ok && !cal_reg && (
        op == supply_cmd_pkg::OP_CAL_COMP ||
        op == supply_cmd_pkg::OP_CAL_HI ||
        op == supply_cmd_pkg::OP_CAL_LO);
    assign prog_err = bad_op || range_err || ceil_err || cal_err;

    // delay starts on setpoint, restart, trigger or output-on
    assign delay_start = cmd_ok && !prog_err && (
        op == supply_cmd_pkg::OP_VOLTAGE_SETPOINT_CMD || op == supply_cmd_pkg::OP_CURRENT_SETPOINT_CMD ||
        op == supply_cmd_pkg::OP_RESTART || op == supply_cmd_pkg::OP_TRIGGER ||
        (op == supply_cmd_pkg::OP_OUT_SET && arg[0]));
    assign suppress  = (delay_cnt_reg != 16'h0000);
    assign cond_cv   = cv_reg && !suppress && mask_reg[supply_cmd_pkg::CV_BIT];
    assign cond_cc   = cc_reg && !suppress && mask_reg[supply_cmd_pkg::CC_BIT];
    // fold trips while in the selected regulation state once the delay has run out
    assign cond_fold = !suppress && !tripped_reg && (
        (fold_reg == supply_cmd_pkg::FOLD_CV && cv_reg) ||
        (fold_reg == supply_cmd_pkg::FOLD_CC && cc_reg));
    // fault set only for unmasked conditions
    assign fault_set = {prog_err && mask_reg[supply_cmd_pkg::ERR_BIT],
                        cond_fold && mask_reg[supply_cmd_pkg::FOLD_BIT],
                        cond_cc, cond_cv};
    assign fault_q = cmd_ok && op == supply_cmd_pkg::OP_FAULT_Q;
    assign accum_q = cmd_ok && op == supply_cmd_pkg::OP_ACCUM_Q;
    assign err_q   = cmd_ok && op == supply_cmd_pkg::OP_ERR_Q;

    // ==================================================================
    // 32 ms tick and delay down-counter
    always_ff @(posedge MCLK_I)
    begin
        if (!RSTN_I || delay_start)
            tick_cnt_reg <= 32'h0;
        else if (tick_cnt_reg == 32'(TICK_CYCLES - 1))
            tick_cnt_reg <= 32'h0;
        else
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end

    always_ff @(posedge MCLK_I)
    begin
        if (!RSTN_I)
            delay_cnt_reg <= 16'h0000;
        else if (delay_start)
            delay_cnt_reg <= delay_set_reg;
        else if (suppress && tick_cnt_reg == 32'(TICK_CYCLES - 1))
            delay_cnt_reg <= delay_cnt_reg - 16'h0001;
    end

    // delay setting, half second after reset
    always_ff @(posedge MCLK_I)
    begin
        if (!RSTN_I)
            delay_set_reg <= supply_cmd_pkg::DELAY_RST_TICKS;
        else if (cmd_ok && !prog_err && op == supply_cmd_pkg::OP_DELAY_SET)
            delay_set_reg <= arg;
    end

    // ==================================================================
    // error code, line discard and indicator
    always_ff @(posedge MCLK_I)
    begin
        if (!RSTN_I)
        begin
            err_code_reg <= supply_cmd_pkg::ERR_NONE;
            discard_reg  <= 1'b0;
            led_reg      <= 1'b0;
        end
        else
        begin
            if (prog_err)
            begin
                led_reg <= 1'b1;
                if (bad_op)
                    err_code_reg <= supply_cmd_pkg::ERR_BAD_OP;
                else if (range_err)
                    err_code_reg <= supply_cmd_pkg::ERR_RANGE;
                else if (ceil_err)
                    err_code_reg <= supply_cmd_pkg::ERR_CEILING;
                else
                    err_code_reg <= supply_cmd_pkg::ERR_NOT_CAL;
            end
            else if (err_q)
                led_reg <= 1'b0;
            // line end ends discard; an error starts it
            if (cmd_go && op == supply_cmd_pkg::OP_LINE_END)
                discard_reg <= 1'b0;
            else if (prog_err)
                discard_reg <= 1'b1;
        end
    end

    // ==================================================================
    // fault and accumulated registers; a new set wins over a query clear
    always_ff @(posedge MCLK_I)
    begin
        if (!RSTN_I)
        begin
            fault_reg <= 4'h0;
            accum_reg <= 4'h0;
        end
        else
        begin
            fault_reg <= (fault_q ? 4'h0 : fault_reg) | fault_set;
            if (accum_q)
                accum_reg <= fault_set;
            else if (err_q)
                accum_reg <= (accum_reg & 4'h7) | fault_set;
            else
                accum_reg <= accum_reg | fault_set;
        end
    end

    // ==================================================================
    // modes, output enable and foldback trip
    always_ff @(posedge MCLK_I)
    begin
        if (!RSTN_I)
        begin
            fold_reg    <= supply_cmd_pkg::FOLD_OFF;
            hold_reg    <= 1'b0;
            cal_reg     <= 1'b0;
            out_reg     <= 1'b1;
            tripped_reg <= 1'b0;
            mask_reg    <= 4'h0;
        end
        else
        begin
            if (cmd_ok && !prog_err)
                case (op)
                    supply_cmd_pkg::OP_FOLD_SET: fold_reg <= arg[1:0];
                    supply_cmd_pkg::OP_HOLD_SET: hold_reg <= arg[0];
                    supply_cmd_pkg::OP_CAL_SET:  cal_reg  <= arg[0];
                    supply_cmd_pkg::OP_OUT_SET:  out_reg  <= arg[0];
                    default:                     ;
                endcase
            if (wr_en && PADDR_I == supply_cmd_pkg::MODE_OFF)
                mask_reg <= PWDATA_I[11:8];
            if (cond_fold)
                tripped_reg <= 1'b1;
            else if (cmd_ok && op == supply_cmd_pkg::OP_RESTART)
                tripped_reg <= 1'b0;
        end
    end

    // ==================================================================
    // setpoints, hold and trigger, ceiling and calibration
    always_ff @(posedge MCLK_I)
    begin
        if (!RSTN_I)
        begin
            current_setpoint_cmd_reg      <= 16'h0000;
            voltage_setpoint_cmd_reg      <= 16'h0000;
            current_setpoint_cmd_pend_reg <= 16'h0000;
            voltage_setpoint_cmd_pend_reg <= 16'h0000;
            ceil_reg      <= supply_cmd_pkg::CEIL_RST;
            slope_reg     <= 16'h0000;
            offset_reg    <= 16'h0000;
            calout_reg    <= 16'h0000;
        end
        else if (cmd_ok && !prog_err)
        begin
            case (op)
                supply_cmd_pkg::OP_CURRENT_SETPOINT_CMD:
                begin
                    current_setpoint_cmd_pend_reg <= arg;
                    if (!hold_reg)
                        current_setpoint_cmd_reg <= arg;
                end
                supply_cmd_pkg::OP_VOLTAGE_SETPOINT_CMD:
                begin
                    voltage_setpoint_cmd_pend_reg <= arg;
                    if (!hold_reg)
                        voltage_setpoint_cmd_reg <= arg;
                end
                supply_cmd_pkg::OP_TRIGGER:
                begin
                    current_setpoint_cmd_reg <= current_setpoint_cmd_pend_reg;
                    voltage_setpoint_cmd_reg <= voltage_setpoint_cmd_pend_reg;
                end
                supply_cmd_pkg::OP_CEIL_SET: ceil_reg <= arg;
                supply_cmd_pkg::OP_CAL_LO:   calout_reg <= CAL_LO_VAL;
                supply_cmd_pkg::OP_CAL_HI:   calout_reg <= CAL_HI_VAL;
                supply_cmd_pkg::OP_CAL_COMP:
                begin
                    // measured hi in arg, lo in bits 23:16 scaled up
                    slope_reg  <= arg - {PWDATA_I[23:16], 8'h00};
                    offset_reg <= {PWDATA_I[23:16], 8'h00};
                end
                default: ;
            endcase
        end
    end

    // ==================================================================
    // query replies and register reads
    always_ff @(posedge MCLK_I)
    begin
        if (!RSTN_I)
            reply_reg <= 32'h0;
        else if (cmd_ok && !prog_err)
            case (op)
                supply_cmd_pkg::OP_DELAY_Q: reply_reg <= {16'h0, delay_set_reg};
                supply_cmd_pkg::OP_ERR_Q:   reply_reg <= {24'h0, err_code_reg};
                supply_cmd_pkg::OP_FAULT_Q: reply_reg <= {28'h0, fault_reg};
                supply_cmd_pkg::OP_FOLD_Q:  reply_reg <= {30'h0, fold_reg};
                supply_cmd_pkg::OP_HOLD_Q:  reply_reg <= {31'h0, hold_reg};
                supply_cmd_pkg::OP_ID_Q:    reply_reg <= {MODEL_NAME, FW_VERSION};
                supply_cmd_pkg::OP_CEIL_Q:  reply_reg <= {16'h0, ceil_reg};
                supply_cmd_pkg::OP_ACCUM_Q: reply_reg <= {28'h0, accum_reg};
                default:                    ;
            endcase
    end

    // read data from a flop, zero on unmapped
    always_ff @(posedge MCLK_I)
    begin
        if (!RSTN_I)
            PRDATA_O <= 32'h0;
        else if (PSEL_I && !PENABLE_I && !PWRITE_I)
            case (PADDR_I)
                supply_cmd_pkg::REPLY_OFF:  PRDATA_O <= reply_reg;
                supply_cmd_pkg::DELAY_OFF:  PRDATA_O <= {16'h0, delay_cnt_reg};
                supply_cmd_pkg::ERR_OFF:    PRDATA_O <= {24'h0, err_code_reg};
                supply_cmd_pkg::FAULT_OFF:  PRDATA_O <= {28'h0, fault_reg};
                supply_cmd_pkg::ACCUM_OFF:  PRDATA_O <= {28'h0, accum_reg};
                supply_cmd_pkg::MODE_OFF:   PRDATA_O <= {20'h0, mask_reg,
                    discard_reg, tripped_reg, out_reg, cal_reg, hold_reg,
                    1'b0, fold_reg};
                supply_cmd_pkg::CURRENT_SETPOINT_CMD_OFF:   PRDATA_O <= {16'h0, current_setpoint_cmd_reg};
                supply_cmd_pkg::CEIL_OFF:   PRDATA_O <= {16'h0, ceil_reg};
                supply_cmd_pkg::CAL_OFF:    PRDATA_O <= {slope_reg, offset_reg};
                supply_cmd_pkg::VOLTAGE_SETPOINT_CMD_OFF:   PRDATA_O <= {16'h0, voltage_setpoint_cmd_reg};
                supply_cmd_pkg::CALOUT_OFF: PRDATA_O <= {16'h0, calout_reg};
                default:                    PRDATA_O <= 32'h0;
            endcase
    end

    assign FAULT_LINE_O = |fault_reg;
    assign ERR_LED_O    = led_reg;
    assign OUTPUT_EN_O  = out_reg && !tripped_reg;

    // ==================================================================
    // assertions
    a_fault_line_any: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        FAULT_LINE_O == (fault_reg != 4'h0))
        else $error("fault line does not follow fault bits");
    a_fault_query_clr: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        fault_q && fault_set == 4'h0 |=> fault_reg == 4'h0)
        else $error("fault query did not clear");
    a_suppress_cv: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        suppress |=> !$rose(fault_reg[supply_cmd_pkg::CV_BIT])
            || !$past(suppress))
        else $error("cv fault during delay");
    a_delay_reload: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        delay_start |=> delay_cnt_reg == $past(delay_set_reg))
        else $error("delay not reloaded");
    a_discard_line: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        prog_err |=> discard_reg && !cmd_ok)
        else $error("line not discarded after error");
    a_trip_holds: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        cond_fold |=> !OUTPUT_EN_O)
        else $error("output not disabled on fold");
    a_ceil_ignored: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        ceil_err |=> $stable(ceil_reg) && $stable(current_setpoint_cmd_reg) && ERR_LED_O)
        else $error("ceiling violation not ignored");
    a_hold_defers: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        hold_reg && cmd_ok && op == supply_cmd_pkg::OP_CURRENT_SETPOINT_CMD
            |=> $stable(current_setpoint_cmd_reg))
        else $error("setpoint applied during hold");
    a_err_accum_clr: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        err_q && !prog_err |=> !accum_reg[supply_cmd_pkg::ERR_BIT])
        else $error("error query left accum bit");
    c_fold_trip: cover property (@(posedge MCLK_I) cond_fold);
    c_prog_err: cover property (@(posedge MCLK_I) prog_err ##1 cmd_go);
    c_trigger: cover property (@(posedge MCLK_I)
        hold_reg && cmd_ok && op == supply_cmd_pkg::OP_TRIGGER);
    c_delay_end: cover property (@(posedge MCLK_I) $fell(suppress));
endmodule

// [supply_cmd_pkg.sv]
// package: register map, field layout, reset values and timing counts
package supply_cmd_pkg;
    // ==================================================================
    // apb register byte offsets
    localparam logic [7:0] CMD_OFF      = 8'h00; // command opcode + argument
    localparam logic [7:0] REPLY_OFF    = 8'h04; // last query answer
    localparam logic [7:0] DELAY_OFF    = 8'h08; // remaining fault_report_delay countdown in ticks
    localparam logic [7:0] ERR_OFF      = 8'h0c; // last error code
    localparam logic [7:0] FAULT_OFF    = 8'h10; // fault register
    localparam logic [7:0] ACCUM_OFF    = 8'h14; // accumulated status
    localparam logic [7:0] MODE_OFF     = 8'h18; // fold/hold/cal/mask/out
    localparam logic [7:0] CURRENT_SETPOINT_CMD_OFF     = 8'h1c; // applied current setpoint
    localparam logic [7:0] CEIL_OFF     = 8'h20; // current_soft_ceiling
    localparam logic [7:0] CAL_OFF      = 8'h24; // cal slope(hi) offset(lo)
    localparam logic [7:0] VOLTAGE_SETPOINT_CMD_OFF     = 8'h28; // applied voltage setpoint
    localparam logic [7:0] CALOUT_OFF   = 8'h2c; // cal point drive value

    // ==================================================================
    // command opcodes in CMD bits 31:24, argument in bits 15:0
    localparam logic [7:0] OP_DELAY_SET = 8'h01;
    localparam logic [7:0] OP_DELAY_Q   = 8'h02;
    localparam logic [7:0] OP_ERR_Q     = 8'h03;
    localparam logic [7:0] OP_FAULT_Q   = 8'h04;
    localparam logic [7:0] OP_FOLD_SET  = 8'h05;
    localparam logic [7:0] OP_FOLD_Q    = 8'h06;
    localparam logic [7:0] OP_HOLD_SET  = 8'h07;
    localparam logic [7:0] OP_HOLD_Q    = 8'h08;
    localparam logic [7:0] OP_ID_Q      = 8'h09;
    localparam logic [7:0] OP_CAL_COMP  = 8'h0a;
    localparam logic [7:0] OP_CAL_HI    = 8'h0b;
    localparam logic [7:0] OP_CAL_LO    = 8'h0c;
    localparam logic [7:0] OP_CEIL_SET  = 8'h0d;
    localparam logic [7:0] OP_CEIL_Q    = 8'h0e;
    localparam logic [7:0] OP_VOLTAGE_SETPOINT_CMD      = 8'h0f;
    localparam logic [7:0] OP_CURRENT_SETPOINT_CMD      = 8'h10;
    localparam logic [7:0] OP_RESTART   = 8'h11;
    localparam logic [7:0] OP_TRIGGER   = 8'h12;
    localparam logic [7:0] OP_OUT_SET   = 8'h13;
    localparam logic [7:0] OP_CAL_SET   = 8'h14;
    localparam logic [7:0] OP_ACCUM_Q   = 8'h15;
    localparam logic [7:0] OP_LINE_END  = 8'h16;

    // ==================================================================
    // condition bit positions (fault, accum and mask share them)
    localparam int CV_BIT   = 0;
    localparam int CC_BIT   = 1;
    localparam int FOLD_BIT = 2;
    localparam int ERR_BIT  = 3;
    localparam int COND_W   = 4;

    // error codes
    localparam logic [7:0] ERR_NONE     = 8'h00;
    localparam logic [7:0] ERR_BAD_OP   = 8'h01;
    localparam logic [7:0] ERR_RANGE    = 8'h02;
    localparam logic [7:0] ERR_CEILING  = 8'h03;
    localparam logic [7:0] ERR_NOT_CAL  = 8'h04;

    // ==================================================================
    // timing: one delay tick is 32 ms, delay counted in ticks
    localparam int CLK_HZ      = 40_000_000;
    localparam int TICK_MS     = 32;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [15:0] DELAY_MAX_TICKS = 16'h03e8; // 32 s / 32 ms
    localparam logic [15:0] DELAY_RST_TICKS = 16'h0010; // 0.5 s rounds up
    localparam logic [15:0] CEIL_RST        = 16'hffff;  // model maximum
    localparam logic [1:0]  FOLD_OFF = 2'h0;
    localparam logic [1:0]  FOLD_CV  = 2'h1;
    localparam logic [1:0]  FOLD_CC  = 2'h2;
endpackage

// [supply_model.sv]
// supply output stage model driving the regulation state lines
`timescale 1ns/100ps
module supply_model (
    input  wire logic       clk_i,
    input  wire logic       out_en_i,
    input  wire logic [1:0] mode_i,
    output logic            cv_o,
    output logic            cc_o
);
    // ==================================================================
    // a disabled output cannot regulate, so both states drop with it
    always_ff @(posedge clk_i)
    begin
        cv_o <= out_en_i & (mode_i == 2'h1);
        cc_o <= out_en_i & (mode_i == 2'h2);
    end
endmodule

// [supply_command_fault_handler_tb_top.sv]
// self-checking bench for the supply command interpreter
`timescale 1ns/100ps
module supply_command_fault_handler_tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  pa = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd, rd;
    logic        prdy, perr, serr, cv, cc, fault, led, oen;
    logic [1:0]  ld = 2'h0;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          n;

    always #12.5 clk = ~clk;

    // short tick keeps the delay counts simulable
    supply_command_fault_handler #(.TICK_CYCLES(8))
        supply_command_fault_handler_inst (
        .MCLK_I(clk), .RSTN_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd),
        .PREADY_O(prdy), .PSLVERR_O(perr), .CV_STATE_I(cv),
        .CC_STATE_I(cc), .FAULT_LINE_O(fault), .ERR_LED_O(led),
        .OUTPUT_EN_O(oen));
    supply_model supply_model_inst (.clk_i(clk), .out_en_i(oen),
        .mode_i(ld), .cv_o(cv), .cc_o(cc));

    task automatic stop_test();
        $display("checks %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string s, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask

    // ==================================================================
    // apb transfer; the request holds until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (prdy !== 1'b1 && k < 50);
        rd = prd;
        serr = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (k >= 50)
        begin
            error_cnt++;
            stop_test();
        end
    endtask

    task automatic cmd(input logic [7:0] op, input logic [15:0] arg);
        apb(1'b1, supply_cmd_pkg::CMD_OFF, {op, 8'h00, arg});
    endtask

    task automatic rdr(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    // issue a query, then fetch the answer word
    task automatic q(input string s, logic [7:0] op, logic [31:0] e);
        cmd(op, 16'h0);
        rdr(supply_cmd_pkg::REPLY_OFF);
        chk(s, e, rd);
    endtask

    // ==================================================================
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        q("dly", supply_cmd_pkg::OP_DELAY_Q, 32'h10);
        q("fold", supply_cmd_pkg::OP_FOLD_Q, 32'h0);
        q("hold", supply_cmd_pkg::OP_HOLD_Q, 32'h0);
        q("err", supply_cmd_pkg::OP_ERR_Q, 32'h0);
        apb(1'b1, supply_cmd_pkg::MODE_OFF, 32'h0f00);
        cmd(supply_cmd_pkg::OP_DELAY_SET, 16'h03e8);
        q("dly", supply_cmd_pkg::OP_DELAY_Q, 32'h3e8);
        cmd(supply_cmd_pkg::OP_DELAY_SET, 16'h03e9);
        cmd(supply_cmd_pkg::OP_DELAY_SET, 16'h0003);
        chk("led", 1, led);
        cmd(supply_cmd_pkg::OP_LINE_END, 16'h0);
        q("dly", supply_cmd_pkg::OP_DELAY_Q, 32'h3e8);
        rdr(supply_cmd_pkg::ACCUM_OFF);
        chk("acc", 1, rd[3]);
        q("err", supply_cmd_pkg::OP_ERR_Q, 32'h2);
        rdr(supply_cmd_pkg::ACCUM_OFF);
        chk("acc", 0, rd[3]);
        chk("line", 1, fault);
        q("fault", supply_cmd_pkg::OP_FAULT_Q, 32'h8);
        chk("line", 0, fault);
        // foldback on cv; trigger opens a 100 tick blind window
        cmd(supply_cmd_pkg::OP_DELAY_SET, 16'h0064);
        cmd(supply_cmd_pkg::OP_FOLD_SET, 16'h0001);
        cmd(supply_cmd_pkg::OP_TRIGGER, 16'h0);
        ld <= 2'h1;
        repeat (40) @(posedge clk);
        chk("out", 1, oen);
        chk("line", 0, fault);
        n = 0;
        while (oen === 1'b1 && n < 1000)
        begin
            @(posedge clk);
            n++;
        end
        chk("late", 1, n > 700);
        chk("trip", 0, oen);
        cmd(supply_cmd_pkg::OP_FAULT_Q, 16'h0);
        rdr(supply_cmd_pkg::REPLY_OFF);
        chk("fold bit", 1, rd[2]);
        chk("held", 0, oen);
        cmd(supply_cmd_pkg::OP_RESTART, 16'h0);
        ld <= 2'h0;
        cmd(supply_cmd_pkg::OP_FOLD_SET, 16'h0002);
        chk("out", 1, oen);
        q("fold", supply_cmd_pkg::OP_FOLD_Q, 32'h2);
        // setpoints wait for the trigger while hold is on
        cmd(supply_cmd_pkg::OP_HOLD_SET, 16'h0001);
        q("hold", supply_cmd_pkg::OP_HOLD_Q, 32'h1);
        cmd(supply_cmd_pkg::OP_CURRENT_SETPOINT_CMD, 16'h0005);
        rdr(supply_cmd_pkg::CURRENT_SETPOINT_CMD_OFF);
        chk("current_setpoint_cmd", 0, rd);
        cmd(supply_cmd_pkg::OP_TRIGGER, 16'h0);
        rdr(supply_cmd_pkg::CURRENT_SETPOINT_CMD_OFF);
        chk("current_setpoint_cmd", 5, rd);
        cmd(supply_cmd_pkg::OP_CEIL_SET, 16'h0003);
        cmd(supply_cmd_pkg::OP_LINE_END, 16'h0);
        q("err", supply_cmd_pkg::OP_ERR_Q, 32'h3);
        q("ceil", supply_cmd_pkg::OP_CEIL_Q, 32'hffff);
        cmd(supply_cmd_pkg::OP_CAL_LO, 16'h0);
        cmd(supply_cmd_pkg::OP_LINE_END, 16'h0);
        q("err", supply_cmd_pkg::OP_ERR_Q, 32'h4);
        cmd(supply_cmd_pkg::OP_CAL_SET, 16'h0001);
        cmd(supply_cmd_pkg::OP_CAL_LO, 16'h0);
        rdr(supply_cmd_pkg::CALOUT_OFF);
        chk("cal", 32'h40, rd);
        // measured lo 0x02 in bits 23:16, hi 0x0500 in bits 15:0
        apb(1'b1, supply_cmd_pkg::CMD_OFF, 32'h0a020500);
        rdr(supply_cmd_pkg::CAL_OFF);
        chk("slope/offset", 32'h03000200, rd);
        q("id", supply_cmd_pkg::OP_ID_Q, 32'h0a5a0101);
        cmd(supply_cmd_pkg::OP_CEIL_SET, 16'h0010);
        q("ceil", supply_cmd_pkg::OP_CEIL_Q, 32'h10);
        cmd(supply_cmd_pkg::OP_CURRENT_SETPOINT_CMD, 16'h0020);
        cmd(supply_cmd_pkg::OP_LINE_END, 16'h0);
        rdr(supply_cmd_pkg::CURRENT_SETPOINT_CMD_OFF);
        chk("current_setpoint_cmd", 5, rd);
        cmd(supply_cmd_pkg::OP_ACCUM_Q, 16'h0);
        rdr(supply_cmd_pkg::ACCUM_OFF);
        chk("acc", 0, rd);
        rdr(8'h40);
        chk("slverr", 1, serr);
        stop_test();
    end
endmodule
